/* File: sbd_dma.sv */
// Byte handoff between a serial bus controller and a transfer controller,
// with the two byte FIFOs that face the link.
// Assumes one clock, a RAM with one cycle read latency, and a link that
// moves bytes by valid/ready.
`timescale 1ns/10ps
`include "sbd_params.svh"

// Byte FIFO with registered flags and head
module sbd_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    // Storage, pointers, fill level and registered flags
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [AW:0]         cnt;
        logic                irdy;
        logic                ovld;
        logic [W-1:0]        head;
    } sbd_fifo_st_t;

    sbd_fifo_st_t s_q;     // Registered state
    sbd_fifo_st_t s_d;     // Next state
    logic         push;    // Accepted write
    logic         pop;     // Accepted read

    // Next state: write, read, flags ahead by one cycle
    always_comb begin
        s_d  = s_q;
        push = in_valid_i && s_q.irdy;
        pop  = out_ready_i && s_q.ovld;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt  = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.irdy = s_d.cnt < (AW+1)'(D);
        s_d.ovld = s_d.cnt != '0;
        s_d.head = s_d.mem[s_d.rd];
    end

    // State register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_o  = s_q.irdy;
    assign out_valid_o = s_q.ovld;
    assign out_data_o  = s_q.head;
endmodule

module sbd_dma (
    input  wire logic                 mclk_i,
    input  wire logic                 nrst_i,
    input  wire sbd_pkg::sbd_cfg_t    cfg_i,
    input  wire sbd_pkg::sbd_dma_cfg_t dma_cfg_i,
    input  wire logic [7:0]           ram_rdata_i,
    input  wire logic                 lk_rx_start_i,
    input  wire logic [7:0]           lk_rx_ctrl_i,
    input  wire logic                 lk_rx_valid_i,
    input  wire logic [7:0]           lk_rx_data_i,
    input  wire logic                 lk_rx_end_i,
    input  wire logic                 lk_tx_ready_i,
    output sbd_pkg::sbd_ram_t         ram_o,
    output logic [7:0]                rd_data_o,
    output logic                      cpu_irq_o,
    output logic [5:0]                dma_cnt_o,
    output logic                      lk_rx_ready_o,
    output logic                      lk_tx_valid_o,
    output logic [7:0]                lk_tx_data_o
);
    sbd_pkg::sbd_state_t s_q;        // Registered state
    sbd_pkg::sbd_state_t s_d;        // Next state
    logic                tick;       // Bus operating clock step
    logic                push_tx;    // Data byte into tx FIFO
    logic                txf_rdy;    // Tx FIFO has room
    logic                txf_vld;    // Tx FIFO still holds bytes
    logic                rxf_vld;    // Rx FIFO holds a byte
    logic [7:0]          rxf_data;   // Rx FIFO head
    logic                pop_rx;     // Rx FIFO byte taken
    logic                take;       // Request taken by transfer ctl
    logic                tx_go;      // Transmission start accepted
    logic                end_evt;    // Communication end this cycle

    // Transmit FIFO between the data register and the link
    sbd_fifo #(.W(8), .D(8)) u_txf (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (push_tx),
        .in_data_i   (s_q.dr),
        .in_ready_o  (txf_rdy),
        .out_valid_o (lk_tx_valid_o),
        .out_data_o  (lk_tx_data_o),
        .out_ready_i (lk_tx_ready_i)
    );
    assign txf_vld = lk_tx_valid_o;

    // Receive FIFO between the link and the data register
    sbd_fifo #(.W(8), .D(8)) u_rxf (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (lk_rx_valid_i && s_q.rx_act),
        .in_data_i   (lk_rx_data_i),
        .in_ready_o  (lk_rx_ready_o),
        .out_valid_o (rxf_vld),
        .out_data_o  (rxf_data),
        .out_ready_i (pop_rx)
    );

    // Next state of the whole block
    always_comb begin
        s_d     = s_q;
        tick    = s_q.div == 2'(`SBD_DIV_LAST);
        s_d.div = tick ? 2'h0 : s_q.div + 2'h1;
        s_d.req = 1'b0;
        end_evt = 1'b0;
        push_tx = tick && s_q.tx_act && s_q.dr_full && txf_rdy
                  && s_q.left != 6'h00 && s_q.dm == sbd_pkg::DM_IDLE;
        pop_rx  = tick && s_q.rx_act && rxf_vld
                  && (s_q.rx_cnt == `SBD_MAX_LEN
                      || (!s_q.dr_full && s_q.dm == sbd_pkg::DM_IDLE));
        take    = s_q.req && s_q.cnt != 6'h00
                  && s_q.dm == sbd_pkg::DM_IDLE && s_q.dm_rx == s_q.last_rx;
        tx_go   = cfg_i.wr && cfg_i.sel == `SBD_SEL_BCR
                  && cfg_i.wdata[`SBD_BCR_EN]
                  && cfg_i.wdata[`SBD_BCR_TX_START]
                  && !s_q.tx_act && !s_q.rx_act && s_q.dr_full
                  && s_q.tx_ctrl == `SBD_CTRL_WRITE
                  && s_q.tx_len != 6'h00;

        // CPU register writes
        if (cfg_i.wr) begin
            unique case (cfg_i.sel)
                `SBD_SEL_DATA: begin
                    s_d.dr      = cfg_i.wdata;
                    s_d.dr_full = 1'b1;
                end
                `SBD_SEL_CTRL, `SBD_SEL_TX_CTRL: begin
                    s_d.tx_ctrl = cfg_i.wdata;
                end
                `SBD_SEL_LEN, `SBD_SEL_TX_LEN: begin
                    s_d.tx_len = cfg_i.wdata[5:0];
                end
                // only the enable bit is writable
                `SBD_SEL_ISR: begin
                    s_d.irq_en = cfg_i.wdata[`SBD_ISR_IRQ_EN];
                end
                `SBD_SEL_BCR: begin
                    s_d.bcr = cfg_i.wdata;
                    s_d.bcr[`SBD_BCR_TX_START] = 1'b0;
                end
                default: begin
                    // Read-only selects ignore writes
                end
            endcase
        end
        // CPU read of the data register frees it
        if (cfg_i.rd && cfg_i.sel == `SBD_SEL_DATA) begin
            s_d.dr_full = 1'b0;
        end

        // Transmission start, length capped to one frame
        if (tx_go) begin
            s_d.tx_act   = 1'b1;
            s_d.last_rx  = 1'b0;
            s_d.comm_end = 1'b0;
            s_d.left = (s_q.tx_len > `SBD_MAX_LEN) ? `SBD_MAX_LEN
                                                   : s_q.tx_len;
        end
        // Reception start when slave receive is armed
        if (lk_rx_start_i && s_q.bcr[`SBD_BCR_EN]
            && s_q.bcr[`SBD_BCR_RX_EN] && !s_q.tx_act && !s_q.rx_act) begin
            s_d.rx_act   = 1'b1;
            s_d.rx_endp  = 1'b0;
            s_d.rx_cnt   = 6'h00;
            s_d.rx_ctrl  = lk_rx_ctrl_i;
            s_d.last_rx  = 1'b1;
            s_d.comm_end = 1'b0;
        end
        if (lk_rx_end_i && s_q.rx_act) begin
            s_d.rx_endp = 1'b1;
        end

        // Bus engine: send data byte, then ask for the next one
        if (push_tx) begin
            s_d.dr_full = 1'b0;
            s_d.left    = s_q.left - 6'h01;
            s_d.req     = s_q.left != 6'h01;
        end
        if (s_q.tx_act && s_q.left == 6'h00 && !txf_vld) begin
            s_d.tx_act   = 1'b0;
            s_d.comm_end = 1'b1;
            end_evt      = 1'b1;
        end
        // Bus engine: hand a received byte over, drop bytes past 32
        if (pop_rx && s_q.rx_cnt != `SBD_MAX_LEN) begin
            s_d.dr      = rxf_data;
            s_d.dr_full = 1'b1;
            s_d.rx_cnt  = s_q.rx_cnt + 6'h01;
            s_d.req     = s_q.rx_ctrl == `SBD_CTRL_WRITE;
        end
        if (s_q.rx_endp && !rxf_vld && !s_q.dr_full
            && s_q.dm == sbd_pkg::DM_IDLE) begin
            s_d.rx_act   = 1'b0;
            s_d.rx_endp  = 1'b0;
            s_d.rx_len   = s_q.rx_cnt;
            s_d.comm_end = 1'b1;
            end_evt      = 1'b1;
        end

        // Transfer controller set-up
        if (dma_cfg_i.arm && s_q.dm == sbd_pkg::DM_IDLE) begin
            s_d.dm_rx = dma_cfg_i.rx;
            s_d.src   = dma_cfg_i.src;
            s_d.dst   = dma_cfg_i.dst;
            s_d.cnt   = dma_cfg_i.cnt;
        end
        // Transfer controller sequence
        s_d.ram.re = 1'b0;
        s_d.ram.we = 1'b0;
        unique case (s_q.dm)
            sbd_pkg::DM_IDLE: begin
                if (take && !s_q.dm_rx) begin
                    s_d.dm       = sbd_pkg::DM_RD;
                    s_d.ram.addr = s_q.src;
                    s_d.ram.re   = 1'b1;
                end else if (take) begin
                    s_d.dm        = sbd_pkg::DM_WR;
                    s_d.ram.addr  = s_q.dst;
                    s_d.ram.wdata = s_q.dr;
                    s_d.ram.we    = 1'b1;
                end
            end
            sbd_pkg::DM_RD: begin
                s_d.dm = sbd_pkg::DM_CAP;
            end
            sbd_pkg::DM_CAP: begin
                s_d.dm      = sbd_pkg::DM_IDLE;
                s_d.dr      = ram_rdata_i;
                s_d.dr_full = 1'b1;
                s_d.src     = s_q.src + 8'h01;
                s_d.cnt     = s_q.cnt - 6'h01;
            end
            sbd_pkg::DM_WR: begin
                s_d.dm      = sbd_pkg::DM_IDLE;
                s_d.dr_full = 1'b0;
                s_d.dst     = s_q.dst + 8'h01;
                s_d.cnt     = s_q.cnt - 6'h01;
            end
        endcase

        // taken requests never reach the CPU
        s_d.irq = s_q.irq_en && (end_evt || (s_q.req && !take));

        // Registered read port
        unique case (cfg_i.sel)
            `SBD_SEL_DATA:    s_d.rd_data = s_q.dr;
            `SBD_SEL_CTRL:    s_d.rd_data = s_q.last_rx ? s_q.rx_ctrl
                                                        : s_q.tx_ctrl;
            `SBD_SEL_TX_CTRL: s_d.rd_data = s_q.tx_ctrl;
            `SBD_SEL_RX_CTRL: s_d.rd_data = s_q.rx_ctrl;
            `SBD_SEL_LEN:     s_d.rd_data = {2'h0, s_q.last_rx ? s_q.rx_len
                                                               : s_q.tx_len};
            `SBD_SEL_TX_LEN:  s_d.rd_data = {2'h0, s_q.tx_len};
            `SBD_SEL_RX_LEN:  s_d.rd_data = {2'h0, s_q.rx_len};
            `SBD_SEL_ISR:     s_d.rd_data = {s_q.irq_en, 4'h0, s_q.comm_end,
                                             s_q.rx_act, s_q.tx_act};
            `SBD_SEL_BCR:     s_d.rd_data = s_q.bcr;
            default:          s_d.rd_data = 8'h00;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ram_o     = s_q.ram;
    assign rd_data_o = s_q.rd_data;
    assign cpu_irq_o = s_q.irq;
    assign dma_cnt_o = s_q.cnt;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // Steps of a transmit and a receive transfer
    sequence s_tx_fetch;
        ram_o.re ##1 (s_q.dm == sbd_pkg::DM_CAP)
        ##1 (s_q.dr == $past(ram_rdata_i));
    endsequence
    sequence s_rx_store;
        ram_o.we && ram_o.wdata == $past(s_q.dr) ##1 !s_q.dr_full;
    endsequence

    a_tx_byte_move: assert property (take && !s_q.dm_rx |=> s_tx_fetch)
        else $error("tx byte not moved from RAM");
    a_rx_byte_move: assert property (take && s_q.dm_rx |=> s_rx_store)
        else $error("rx byte not moved to RAM");
    a_tx_src_step: assert property (take && !s_q.dm_rx |=> ##2
        s_q.src == $past(s_q.src, 3) + 8'h01 && s_q.dst == $past(s_q.dst, 3))
        else $error("tx addresses wrong");
    a_rx_dst_step: assert property (take && s_q.dm_rx |=> ##1
        s_q.dst == $past(s_q.dst, 2) + 8'h01 && s_q.src == $past(s_q.src, 2))
        else $error("rx addresses wrong");
    a_last_no_req: assert property (push_tx && s_q.left == 6'h01
        |=> !s_q.req) else $error("request on last tx byte");
    a_irq_suppress: assert property (take |=> !cpu_irq_o)
        else $error("taken request reached CPU");
    a_frame_limit: assert property (s_q.rx_cnt <= `SBD_MAX_LEN)
        else $error("more than a frame received");
    a_ctrl_gate: assert property (s_q.req && s_q.last_rx
        |-> s_q.rx_ctrl == `SBD_CTRL_WRITE) else $error("non-write request");
    a_tick_space: assert property (tick |=> !tick [*3] ##1 tick)
        else $error("bus clock not divided by four");
    a_isr_write: assert property (cfg_i.wr && cfg_i.sel == `SBD_SEL_ISR
        |=> s_q.irq_en == $past(cfg_i.wdata[`SBD_ISR_IRQ_EN])
            && $stable(s_q.bcr) && $stable(s_q.tx_ctrl))
        else $error("status write misbehaved");
    a_cnt_stop: assert property (s_q.req && s_q.cnt == 6'h00
        |=> s_q.dm == sbd_pkg::DM_IDLE && $stable(s_q.cnt))
        else $error("transfer at zero count");
endmodule

/* File: sbd_far_model.sv */
// Far side model: byte RAM of the transfer controller and a link sink.
// Assumes the RAM request is registered and answered one cycle later.
`timescale 1ns/10ps
module sbd_far_model (
    input  wire logic              mclk_i,
    input  wire sbd_pkg::sbd_ram_t ram_i,
    output logic [7:0]             ram_rdata_o,
    input  wire logic              tx_valid_i,
    input  wire logic [7:0]        tx_data_i,
    output logic                   tx_ready_o
);
    logic [7:0] mem [256];  // Byte store
    logic [7:0] sent [$];   // Bytes taken off the link
    int         n_rd;       // Reads seen
    int         n_wr;       // Writes seen

    // Quiet start
    initial begin
        ram_rdata_o = 8'h00;
        tx_ready_o  = 1'b0;
        n_rd        = 0;
        n_wr        = 0;
    end

    // RAM: data one cycle after a read, a toggling pattern otherwise
    always @(posedge mclk_i) begin
        if (ram_i.re === 1'b1) begin
            ram_rdata_o <= mem[ram_i.addr];
            n_rd        <= n_rd + 1;
        end else begin
            ram_rdata_o <= ~ram_rdata_o;
        end
        if (ram_i.we === 1'b1) begin
            mem[ram_i.addr] <= ram_i.wdata;
            n_wr            <= n_wr + 1;
        end
    end

    // Sink: ready at random on one cycle in four on average, so the transmit FIFO backs up
    always @(posedge mclk_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o)
            sent.push_back(tx_data_i);
        tx_ready_o <= ($urandom_range(3) == 0);
    end
endmodule

/* File: sbd_params.svh */
// Constants of the serial bus byte handoff and its transfer controller.
// Assumes inclusion by the package and the design file by bare name.
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH

// Clock figures in MHz and the divider that gives the bus operating clock
`define SBD_SYS_MHZ       32
`define SBD_OP_MHZ        8
`define SBD_DIV_LAST      (`SBD_SYS_MHZ / `SBD_OP_MHZ - 1)

// Frame limit of communication mode 1 and the data-write control bits
`define SBD_MAX_LEN       6'h20
`define SBD_CTRL_WRITE    8'h0f
`define SBD_MODE1         1'h1

// Register selects on the configuration port
`define SBD_SEL_DATA      4'h0
`define SBD_SEL_CTRL      4'h1
`define SBD_SEL_TX_CTRL   4'h2
`define SBD_SEL_RX_CTRL   4'h3
`define SBD_SEL_LEN       4'h4
`define SBD_SEL_TX_LEN    4'h5
`define SBD_SEL_RX_LEN    4'h6
`define SBD_SEL_ISR       4'h7
`define SBD_SEL_BCR       4'h8

// Bit positions in the bus control and interrupt status registers
`define SBD_BCR_EN        7
`define SBD_BCR_TX_START  6
`define SBD_BCR_RX_EN     3
`define SBD_ISR_IRQ_EN    7

// Reset values
`define SBD_BCR_RST       8'h00
`define SBD_CTRL_RST      8'h00
`define SBD_LEN_RST       6'h00

`endif

/* File: sbd_pkg.sv */
// Types of the serial bus byte handoff block.
// Assumes sbd_params.svh is on the include path.
`include "sbd_params.svh"

package sbd_pkg;

    // Transfer controller sequencing
    typedef enum logic [1:0] {
        DM_IDLE,
        DM_RD,
        DM_CAP,
        DM_WR
    } sbd_dm_st_t;

    // Request towards the RAM
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } sbd_ram_t;

    // CPU register access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] sel;
        logic [7:0] wdata;
    } sbd_cfg_t;

    // Transfer controller set-up
    typedef struct packed {
        logic       arm;
        logic       rx;
        logic [7:0] src;
        logic [7:0] dst;
        logic [5:0] cnt;
    } sbd_dma_cfg_t;

    // All state of the handoff block outside its two FIFOs
    typedef struct packed {
        logic [1:0] div;
        logic [7:0] bcr;
        logic       irq_en;
        logic [7:0] tx_ctrl;
        logic [5:0] tx_len;
        logic [7:0] rx_ctrl;
        logic [5:0] rx_len;
        logic       last_rx;
        logic [7:0] dr;
        logic       dr_full;
        logic       tx_act;
        logic       rx_act;
        logic       rx_endp;
        logic [5:0] left;
        logic [5:0] rx_cnt;
        logic       comm_end;
        logic       req;
        sbd_dm_st_t dm;
        logic       dm_rx;
        logic [7:0] src;
        logic [7:0] dst;
        logic [5:0] cnt;
        sbd_ram_t   ram;
        logic [7:0] rd_data;
        logic       irq;
    } sbd_state_t;

endpackage

/* File: serial_bus_dma_byte_transfer_tb.sv */
// Self-checking bench of the byte handoff block with a far side model.
// Assumes sbd_params.svh on the include path and the package compiled.
`timescale 1ns/10ps
`include "sbd_params.svh"
module serial_bus_dma_byte_transfer_tb;
    logic                  mclk_i;         // 250 MHz clock
    logic                  nrst_i;         // Reset, active low
    sbd_pkg::sbd_cfg_t     cfg_i;          // Register port
    sbd_pkg::sbd_dma_cfg_t dma_cfg_i;      // Transfer set-up
    logic [7:0]            ram_rdata_i;    // RAM answer
    logic                  lk_rx_start_i;  // Frame start
    logic [7:0]            lk_rx_ctrl_i;   // Frame control bits
    logic                  lk_rx_valid_i;  // Received byte valid
    logic [7:0]            lk_rx_data_i;   // Received byte
    logic                  lk_rx_end_i;    // Frame end
    logic                  lk_tx_ready_i;  // Sink ready
    sbd_pkg::sbd_ram_t     ram_o;          // RAM request
    logic [7:0]            rd_data_o;      // Register read data
    logic                  cpu_irq_o;      // CPU interrupt
    logic [5:0]            dma_cnt_o;      // Remaining count
    logic                  lk_rx_ready_o;  // Receive FIFO room
    logic                  lk_tx_valid_o;  // Transmit byte valid
    logic [7:0]            lk_tx_data_o;   // Transmit byte
    int                    errors;         // Mismatches
    int                    n_tests;        // Comparisons
    int                    n_irq;          // Interrupt pulses
    logic [7:0]            v;              // Read scratch

    sbd_dma sbd_dma_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
        .dma_cfg_i(dma_cfg_i), .ram_rdata_i(ram_rdata_i),
        .lk_rx_start_i(lk_rx_start_i), .lk_rx_ctrl_i(lk_rx_ctrl_i),
        .lk_rx_valid_i(lk_rx_valid_i), .lk_rx_data_i(lk_rx_data_i),
        .lk_rx_end_i(lk_rx_end_i), .lk_tx_ready_i(lk_tx_ready_i),
        .ram_o(ram_o), .rd_data_o(rd_data_o), .cpu_irq_o(cpu_irq_o),
        .dma_cnt_o(dma_cnt_o), .lk_rx_ready_o(lk_rx_ready_o),
        .lk_tx_valid_o(lk_tx_valid_o), .lk_tx_data_o(lk_tx_data_o));
    sbd_far_model far_inst (.mclk_i(mclk_i), .ram_i(ram_o),
        .ram_rdata_o(ram_rdata_i), .tx_valid_i(lk_tx_valid_o),
        .tx_data_i(lk_tx_data_o), .tx_ready_o(lk_tx_ready_i));

    // Clock and interrupt pulse count
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (cpu_irq_o === 1'b1) n_irq <= n_irq + 1;

    // Verdict and end of run
    task wrap_up;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Compare one value
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait ran out
    task tmo(input int i, input int lim);
        if (i >= lim) begin
            errors++;
            wrap_up;
        end
    endtask

    // Remaining count after n requests
    function automatic int exp_left(input int cnt, input int n);
        return (cnt > n) ? cnt - n : 0;
    endfunction

    // One register write pulse
    task wr(input logic [3:0] s, input logic [7:0] d);
        @(posedge mclk_i);
        cfg_i.wr    <= 1'b1;
        cfg_i.sel   <= s;
        cfg_i.wdata <= d;
        @(posedge mclk_i);
        cfg_i.wr    <= 1'b0;
    endtask

    // Register read; r frees the data register
    task rd(input logic [3:0] s, input logic r, output logic [7:0] q);
        @(posedge mclk_i);
        cfg_i.sel <= s;
        cfg_i.rd  <= r;
        @(posedge mclk_i);
        cfg_i.rd  <= 1'b0;
        @(negedge mclk_i);
        q = rd_data_o;
    endtask

    // Load the transfer controller
    task arm(input logic rx, input logic [7:0] a, input logic [5:0] c);
        @(posedge mclk_i);
        dma_cfg_i <= '{1'b1, rx, a, a, c};
        @(posedge mclk_i);
        dma_cfg_i.arm <= 1'b0;
    endtask

    // Master transmission of n bytes
    task tx_case(input int n, input logic alt);
        int i, k, base, r0, s0, q0;
        logic [7:0] b0;
        base = $urandom_range(200);
        b0 = $urandom;
        for (k = 0; k < n; k++) far_inst.mem[base+k] = $urandom;
        r0 = far_inst.n_rd;
        s0 = far_inst.sent.size();
        q0 = n_irq;
        wr(alt ? `SBD_SEL_CTRL : `SBD_SEL_TX_CTRL, `SBD_CTRL_WRITE);
        wr(alt ? `SBD_SEL_LEN : `SBD_SEL_TX_LEN, 8'(n));
        wr(`SBD_SEL_DATA, b0);
        arm(1'b0, 8'(base), 6'(n - 1));
        wr(`SBD_SEL_BCR, 8'hc8);
        for (i = 0; i < 3000 && far_inst.sent.size() < s0 + n; i++)
            @(posedge mclk_i);
        tmo(i, 3000);
        for (i = 0; i < 60; i++) begin
            rd(`SBD_SEL_ISR, 1'b0, v);
            if (v[2] === 1'b1) break;
        end
        tmo(i, 60);
        repeat (4) @(posedge mclk_i);
        check(far_inst.sent[s0], b0);
        for (k = 1; k < n; k++)
            check(far_inst.sent[s0+k], far_inst.mem[base+k-1]);
        check(far_inst.n_rd - r0, n - 1);
        check(dma_cnt_o, 0);
        check(n_irq - q0, 1);
        rd(alt ? `SBD_SEL_TX_CTRL : `SBD_SEL_CTRL, 1'b0, v);
        check(v, `SBD_CTRL_WRITE);
    endtask

    // Slave reception of m bytes, count cnt, control bits c
    task rx_case(input int m, input int cnt, input logic [7:0] c,
                 input logic alt);
        int i, k, base, w0, q0, ew, rl;
        logic [7:0] d [33];
        base = $urandom_range(200);
        w0 = far_inst.n_wr;
        q0 = n_irq;
        // Bytes past one frame are dropped by the bus engine
        rl = (m > 32) ? 32 : m;
        ew = (c == `SBD_CTRL_WRITE) ? ((rl < cnt) ? rl : cnt) : 0;
        wr(`SBD_SEL_BCR, 8'h88);
        arm(1'b1, 8'(base), 6'(cnt));
        @(posedge mclk_i);
        lk_rx_start_i <= 1'b1;
        lk_rx_ctrl_i  <= c;
        @(posedge mclk_i);
        lk_rx_start_i <= 1'b0;
        // Bytes on every other cycle fill the receive FIFO, each held while it refuses
        for (k = 0; k < m; k++) begin
            d[k] = $urandom;
            @(posedge mclk_i);
            lk_rx_valid_i <= 1'b1;
            lk_rx_data_i  <= d[k];
            for (i = 0; i < 200; i++) begin
                @(negedge mclk_i);
                if (lk_rx_ready_o === 1'b1) break;
            end
            tmo(i, 200);
            @(posedge mclk_i);
            lk_rx_valid_i <= 1'b0;
            lk_rx_data_i  <= ~d[k];
        end
        @(posedge mclk_i);
        lk_rx_end_i <= 1'b1;
        @(posedge mclk_i);
        lk_rx_end_i <= 1'b0;
        // Unserviced last byte is left for the CPU, and blocks the end
        if (ew < rl) begin
            repeat (40) @(posedge mclk_i);
            rd(`SBD_SEL_DATA, 1'b1, v);
            check(v, d[rl-1]);
        end
        // Wait for communication end, then read the length
        for (i = 0; i < 200; i++) begin
            rd(`SBD_SEL_ISR, 1'b0, v);
            if (v[2] === 1'b1) break;
        end
        tmo(i, 200);
        repeat (4) @(posedge mclk_i);
        rd(alt ? `SBD_SEL_LEN : `SBD_SEL_RX_LEN, 1'b0, v);
        check(v, rl);
        rd(alt ? `SBD_SEL_CTRL : `SBD_SEL_RX_CTRL, 1'b0, v);
        check(v, c);
        check(far_inst.n_wr - w0, ew);
        for (k = 0; k < ew; k++)
            check(far_inst.mem[base+k], d[k]);
        check(dma_cnt_o, (ew > 0) ? exp_left(cnt, rl) : cnt);
        // One end pulse plus one per unserviced data request
        check(n_irq - q0,
              1 + ((c == `SBD_CTRL_WRITE) ? rl - ew : 0));
    endtask

    // Main sequence
    initial begin
        void'($urandom(24));
        errors = 0;
        n_tests = 0;
        n_irq = 0;
        mclk_i = 1'b0;
        nrst_i = 1'b0;
        cfg_i = '0;
        dma_cfg_i = '0;
        lk_rx_start_i = 1'b0;
        lk_rx_ctrl_i = 8'h00;
        lk_rx_valid_i = 1'b0;
        lk_rx_data_i = 8'h00;
        lk_rx_end_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(`SBD_SEL_ISR, 1'b0, v);
        check(v, 8'h00);
        rd(`SBD_SEL_BCR, 1'b0, v);
        check(v, `SBD_BCR_RST);
        // only the enable bit takes a write
        wr(`SBD_SEL_ISR, 8'hff);
        rd(`SBD_SEL_ISR, 1'b0, v);
        check(v, 8'h80);
        tx_case(2, 1'b0);
        tx_case(32, 1'b1);
        tx_case(1, 1'b0);
        repeat (2) tx_case($urandom_range(3, 31), 1'($urandom_range(1)));
        rx_case(5, 32, `SBD_CTRL_WRITE, 1'b0);
        rx_case(32, 32, `SBD_CTRL_WRITE, 1'b1);
        rx_case(3, 2, `SBD_CTRL_WRITE, 1'b0);
        rx_case(1, 32, 8'h3c, 1'b1);
        rx_case(33, 32, `SBD_CTRL_WRITE, 1'b1);
        rx_case($urandom_range(1, 32), 32, `SBD_CTRL_WRITE, 1'b0);
        wrap_up;
    end
endmodule
